// file: pmic_io_and_button_logic_tb.sv
// Self-checking bench of the PMIC I/O and push-button block
`timescale 1ns/100ps
module pmic_io_and_button_logic_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  // Short counts keep the run small; expectations derive from them
  localparam int TD = 4;
  localparam int PU = 4;
  localparam int L8 = 20;
  localparam int L15 = 26;
  localparam int PD = 3;
  localparam logic [5:0] R1D = 6'h14;
  localparam logic [5:0] R2D = 6'h0A;
  localparam logic [5:0] R3P = 6'h24;
  logic clk, rst, psel, pen, pwr, prdy, perr, err, pg, s1, s3, pb, h1, h3;
  logic held, o1, oe1, o2, oe2, o3, oe3, wk, irq, ren, p1, p2, p3;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd, sd;
  logic [2:0] band;
  logic [5:0] r1, r2, r3, r4;
  logic [5:0] t3 [8];
  logic [5:0] t4 [8];
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, k;

  pmiob_top #(.TICK_DIV(TD), .PWRUP_T(PU), .LONG8_T(L8), .LONG15_T(L15),
    .PDOWN_T(PD), .R3_PROG(R3P), .R1_DEF(R1D), .R2_DEF(R2D)) dut_u (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .SEL_BAND(band), .POWER_GOOD(pg), .SEQ_PIN1(s1), .SEQ_PIN3(s3),
    .PUSH_BUTTON_I(pb), .IO_PIN_ONE_I(p1), .IO_PIN_ONE_O(o1),
    .IO_PIN_ONE_OE(oe1), .OUT_PIN_TWO_O(o2), .OUT_PIN_TWO_OE(oe2),
    .IO_PIN_THREE_I(p3), .IO_PIN_THREE_O(o3), .IO_PIN_THREE_OE(oe3),
    .WAKE_PULSE_N(wk), .IRQ_N(irq), .RAILS_EN(ren), .RAIL1_CODE(r1),
    .RAIL2_CODE(r2), .RAIL3_CODE(r3), .RAIL4_CODE(r4));
  pmiob_host_model host_u (.io1_o(o1), .io1_oe(oe1), .io2_o(o2),
    .io2_oe(oe2), .io3_o(o3), .io3_oe(oe3), .ddr_rst_lvl(h1),
    .core_rst_lvl(h3), .pin1(p1), .pin2(p2), .pin3(p3));

  // ------------------------------------------------------------
  // Clock, timeout and tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The whole sequence needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (prdy !== 1'b1 && t < 20);
    chk("pready", 1, prdy);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Reference of the three pins for a control word and the pin inputs
  task automatic ckpins(input logic [11:0] c);
    logic e1, l2;
    e1 = !c[3] && !(c[8] ? s1 : c[0]);
    l2 = !c[3] ? c[1] : (pg ? h1 : held);
    chk("pin1_oe", e1, oe1);
    chk("pin1", e1 ? 1'b0 : h1, p1);
    chk("pin2", l2, p2);
    chk("pin2_oe", c[4] | !l2, oe2);
    chk("pin3_oe", !c[5] && !(c[9] ? s3 : c[2]), oe3);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    t3 = '{6'h0C, 6'h12, 6'h18, R3P, 6'h3D, 6'h0C, 6'h0C, 6'h0C};
    t4 = '{6'h32, 6'h32, 6'h32, 6'h32, 6'h01, 6'h07, 6'h0D, 6'h14};
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 12'h000;
    pwd = 32'h00000000;
    band = 3'h0;
    pg = 1'b0;
    s1 = 1'b0;
    s3 = 1'b0;
    pb = 1'b1;
    h1 = 1'b1;
    h3 = 1'b1;
    held = 1'b0;
    sd = 32'h00016B96;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h007, rd);
    apb(0, 12'h00C, 0);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    apb(1, 12'h00C, 32'hFFFFFFFF);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h007, rd);
    for (k = 0; k < 8; k++) begin
      band <= 3'(k);
      repeat (12) @(posedge clk);
      chk("rail3", t3[k], r3);
      chk("rail4", t4[k], r4);
    end
    apb(1, 12'h000, 32'h0F);
    repeat (4) @(posedge clk);
    ckpins(12'h00F);
    pg <= 1'b1;
    repeat (4) @(posedge clk);
    ckpins(12'h00F);
    pg <= 1'b0;
    held = 1'b1;
    repeat (4) @(posedge clk);
    h1 <= 1'b0;
    repeat (4) @(posedge clk);
    ckpins(12'h00F);
    pg <= 1'b1;
    for (k = 0; k < 16; k++) begin
      sd = lfsr(sd);
      s1 <= sd[16];
      s3 <= sd[17];
      h1 <= sd[18];
      apb(1, 12'h000, sd & 32'h33F);
      repeat (4) @(posedge clk);
      ckpins(sd[11:0] & 12'h33F);
      apb(0, 12'h000, 0);
      chk("ctrl", sd & 32'h33F, rd);
    end
    apb(1, 12'h000, 32'h07);
    pb <= 1'b0;
    repeat (2 * TD) @(posedge clk);
    pb <= 1'b1;
    repeat (12 * TD) @(posedge clk);
    chk("rails_en", 0, ren);
    pb <= 1'b0;
    n = 0;
    while (ren !== 1'b1 && n < 40 * TD) begin
      @(posedge clk);
      n++;
    end
    chk("pwrup", 1, n >= PU * TD && ren === 1'b1);
    pb <= 1'b1;
    repeat (12 * TD) @(posedge clk);
    apb(0, 12'h004, 0);
    chk("level", 1, rd[0]);
    chk("state", 1, rd[5:4]);
    repeat (4) @(posedge clk);
    chk("irq_n", 1, irq);
    for (k = 0; k < 2; k++) begin
      apb(1, 12'h000, {25'h0, k[0], 6'h07});
      pb <= 1'b0;
      n = 0;
      while (wk !== 1'b0 && n < 8 * TD) begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (wk === 1'b0 && n < 40 * TD) begin
        @(posedge clk);
        n++;
      end
      chk("wake_len", 5 * TD, n);
      chk("irq_n", k[0], irq);
      apb(0, 12'h004, 0);
      chk("event", 2, rd[1:0]);
      pb <= 1'b1;
      repeat (6 * TD) @(posedge clk);
      chk("wake_n", 1, wk);
      chk("irq_n", k[0], irq);
      apb(0, 12'h004, 0);
      repeat (4) @(posedge clk);
      chk("irq_clr", 1, irq);
    end
    apb(1, 12'h008, {20'h0, 6'h2A, 6'h05});
    n = 0;
    while ((r1 !== 6'h05 || r2 !== 6'h2A) && n < 200 * TD) begin
      @(posedge clk);
      n++;
    end
    chk("rail1", 6'h05, r1);
    chk("rail2", 6'h2A, r2);
    apb(1, 12'h000, 32'h427);
    repeat (4 * TD) @(posedge clk);
    h3 <= 1'b0;
    k = 0;
    n = 0;
    while ((r1 !== R1D || r2 !== R2D) && n < 200 * TD) begin
      @(posedge clk);
      n++;
      if (ren !== 1'b1)
        k++;
    end
    chk("rail1", R1D, r1);
    chk("rail2", R2D, r2);
    chk("rails_off", 0, k);
    chk("ramp", 1, n >= 62 * TD);
    chk("rail3", t3[7], r3);
    chk("rail4", t4[7], r4);
    apb(0, 12'h004, 0);
    chk("pin3_evt", 1, rd[2]);
    chk("pin3_oe", 0, oe3);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h427, rd);
    h3 <= 1'b1;
    for (k = 0; k < 2; k++) begin
      apb(1, 12'h000, {24'h0, k[0], 7'h07});
      pb <= 1'b0;
      n = 0;
      while (ren !== 1'b0 && n < 40 * TD) begin
        @(posedge clk);
        n++;
      end
      chk("long", 1, n >= (k ? L15 : L8) * TD &&
        n <= ((k ? L15 : L8) + 4) * TD);
      n = 0;
      while (ren !== 1'b1 && n < (PD + 4) * TD) begin
        @(posedge clk);
        n++;
      end
      chk("restart", 1, ren === 1'b1 && n >= PD * TD);
      n = 0;
      while (ren !== 1'b0 && n < 80 * TD) begin
        @(posedge clk);
        n++;
      end
      chk("repeat", 0, ren);
      pb <= 1'b1;
      n = 0;
      while (ren !== 1'b1 && n < 20 * TD) begin
        @(posedge clk);
        n++;
      end
      chk("resume", 1, ren);
    end
    conclude();
  end
endmodule

// file: pmiob_cfg.svh
// Constants of the PMIC I/O and push-button block
`ifndef PMIOB_CFG_SVH
`define PMIOB_CFG_SVH
// APB register offsets
`define PMIOB_CTRL_OFF 12'h000
`define PMIOB_STAT_OFF 12'h004
`define PMIOB_RAIL_OFF 12'h008
// Control register fields
`define PMIOB_C_PIN1_OUTPUT_BIT 0
`define PMIOB_C_PIN2_OUTPUT_BIT 1
`define PMIOB_C_PIN3_OUTPUT_BIT 2
`define PMIOB_C_IO1SEL 3
`define PMIOB_C_BUF2 4
`define PMIOB_C_DC12 5
`define PMIOB_C_PBM 6
`define PMIOB_C_LONG 7
`define PMIOB_C_SEQ1 8
`define PMIOB_C_SEQ3 9
`define PMIOB_C_RAMP 10
`define PMIOB_CTRL_W 12
`define PMIOB_CTRL_RST 12'h007
// Status register fields
`define PMIOB_S_LEVEL 0
`define PMIOB_S_IRQ 1
`define PMIOB_S_RESET 2
`define PMIOB_S_PWR 3
`define PMIOB_S_STATE 4
// Rail default codes
`define PMIOB_R3_B0 6'h0C
`define PMIOB_R3_B1 6'h12
`define PMIOB_R3_B2 6'h18
`define PMIOB_R3_B4 6'h3D
`define PMIOB_R4_LOW 6'h32
`define PMIOB_R4_B4 6'h01
`define PMIOB_R4_B5 6'h07
`define PMIOB_R4_B6 6'h0D
`define PMIOB_R4_B7 6'h14
// Timing at the 32 kHz tick
`define PMIOB_CLK_HZ 20000000
`define PMIOB_SLOW_HZ 32768
`define PMIOB_TICK_DIV (`PMIOB_CLK_HZ / `PMIOB_SLOW_HZ)
`define PMIOB_PWRUP_MS 600
`define PMIOB_LONG8_MS 8000
`define PMIOB_LONG15_MS 15000
`define PMIOB_PDOWN_MS 500
`define PMIOB_WAKE_TICKS 5
`define PMIOB_MS2T(ms) (((ms) * `PMIOB_SLOW_HZ + 999) / 1000)
`endif

// file: pmiob_host_model.sv
// Host-side model of the three shared pins and their board pull-ups
`timescale 1ns/100ps
module pmiob_host_model (
  input wire logic io1_o,
  input wire logic io1_oe,
  input wire logic io2_o,
  input wire logic io2_oe,
  input wire logic io3_o,
  input wire logic io3_oe,
  input wire logic ddr_rst_lvl,
  input wire logic core_rst_lvl,
  output logic pin1,
  output logic pin2,
  output logic pin3
);
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // A released pin two rises through its pull-up; released pins one and three take the host reset levels
  assign pin1 = io1_oe ? io1_o : ddr_rst_lvl;
  assign pin2 = io2_oe ? io2_o : 1'b1;
  assign pin3 = io3_oe ? io3_o : core_rst_lvl;
endmodule

// file: pmiob_pkg.sv
// Types of the PMIC I/O and push-button block
package pmiob_pkg;
  typedef enum logic [1:0] {
    PMIOB_OFF,
    PMIOB_ACTIVE,
    PMIOB_DOWN
  } pmiob_state_e;
  typedef logic [5:0] pmiob_code_t;
endpackage

// file: pmiob_top.sv
// PMIC digital I/O, rail default selection and push-button logic
// What this block does
// - Band 0..7 loads rail three code 0C,12,18,programmed,3D,0C,0C,0C.
// - Bands 0..3 load rail four code 32; bands 4..7 load 01,07,0D,14.
// - Memory-reset mode off: pin one open-drain from its bit or sequencer.
// - Mode on, power good high: pin two follows pin one level.
// - Mode on, power good low: pin two low after reset, else held.
// - Mode off: pin two follows its own output bit.
// - Buffer type bit picks open-drain or push-pull for pin two.
// - Core reset off: pin three open-drain from its bit or sequencer.
// - Core reset on: pin three is an undriven active-low reset input.
// - Falling pin three restores only rail one and two codes.
// - Restored rails ramp to defaults at the set rate, staying on.
// - Power-up starts only after the button is low for 600 ms.
// - Active: every button level change raises a maskable interrupt.
// - A readable flag always shows the present button level.
// - Active: wake output low five slow cycles on each button fall.
// - Button low 8 s or 15 s disables rails and enters state_a.
// - After the 500 ms power-down the device restarts regardless.
// - Button kept low repeats the restart once per interval.
// - Host read clears event bits; persisting event sets them again.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "pmiob_cfg.svh"
module pmiob_top
  import pmiob_pkg::*;
#(
  parameter int TICK_DIV = `PMIOB_TICK_DIV,
  parameter int PWRUP_T = `PMIOB_MS2T(`PMIOB_PWRUP_MS),
  parameter int LONG8_T = `PMIOB_MS2T(`PMIOB_LONG8_MS),
  parameter int LONG15_T = `PMIOB_MS2T(`PMIOB_LONG15_MS),
  parameter int PDOWN_T = `PMIOB_MS2T(`PMIOB_PDOWN_MS),
  parameter logic [5:0] R3_PROG = 6'h24,
  parameter logic [5:0] R1_DEF = 6'h14,
  parameter logic [5:0] R2_DEF = 6'h0A
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] SEL_BAND,
  input wire logic POWER_GOOD,
  input wire logic SEQ_PIN1,
  input wire logic SEQ_PIN3,
  input wire logic PUSH_BUTTON_I,
  input wire logic IO_PIN_ONE_I,
  output logic IO_PIN_ONE_O,
  output logic IO_PIN_ONE_OE,
  output logic OUT_PIN_TWO_O,
  output logic OUT_PIN_TWO_OE,
  input wire logic IO_PIN_THREE_I,
  output logic IO_PIN_THREE_O,
  output logic IO_PIN_THREE_OE,
  output logic WAKE_PULSE_N,
  output logic IRQ_N,
  output logic RAILS_EN,
  output logic [5:0] RAIL1_CODE,
  output logic [5:0] RAIL2_CODE,
  output logic [5:0] RAIL3_CODE,
  output logic [5:0] RAIL4_CODE
);

  // ------------------------------------------------------------
  // Rail default decode
  // ------------------------------------------------------------
  function automatic pmiob_code_t r3_code(input logic [2:0] b);
    case (b)
      3'h1: r3_code = `PMIOB_R3_B1;
      3'h2: r3_code = `PMIOB_R3_B2;
      3'h3: r3_code = R3_PROG;
      3'h4: r3_code = `PMIOB_R3_B4;
      default: r3_code = `PMIOB_R3_B0;
    endcase
  endfunction

  function automatic pmiob_code_t r4_code(input logic [2:0] b);
    case (b)
      3'h4: r4_code = `PMIOB_R4_B4;
      3'h5: r4_code = `PMIOB_R4_B5;
      3'h6: r4_code = `PMIOB_R4_B6;
      3'h7: r4_code = `PMIOB_R4_B7;
      default: r4_code = `PMIOB_R4_LOW;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Registers and bus
  // ------------------------------------------------------------
  logic [`PMIOB_CTRL_W-1:0] ctrl_r;
  logic irq_r, core_rst_evt_r, ramping_r;
  logic [5:0] r1_target_r, r2_target_r;
  pmiob_state_e state_r;
  logic btn_lvl, irq_set, rst_evt_set;

  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire rd_stat = acc && !PWRITE && PADDR == `PMIOB_STAT_OFF;
  wire mapped = PADDR == `PMIOB_CTRL_OFF || PADDR == `PMIOB_STAT_OFF ||
    PADDR == `PMIOB_RAIL_OFF;

  wire io1sel = ctrl_r[`PMIOB_C_IO1SEL];
  wire dc12 = ctrl_r[`PMIOB_C_DC12];

  // Zero-wait slave: answers in the first access cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA <= 32'h0;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `PMIOB_CTRL_OFF: PRDATA <= {20'h0, ctrl_r};
          `PMIOB_STAT_OFF: PRDATA <= {26'h0, state_r, ramping_r,
            core_rst_evt_r, irq_r, btn_lvl};
          `PMIOB_RAIL_OFF: PRDATA <= {8'h0, RAIL4_CODE, RAIL3_CODE,
            RAIL2_CODE, RAIL1_CODE};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end

  // Access phase lasts one cycle, PREADY registered from setup
  wire done = acc && PREADY;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= `PMIOB_CTRL_RST;
    end else if (done && PWRITE && PADDR == `PMIOB_CTRL_OFF) begin
      ctrl_r <= PWDATA[`PMIOB_CTRL_W-1:0];
    end
  end

  // Event bits: a set in the same cycle as the read-clear wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_r <= 1'b0;
      core_rst_evt_r <= 1'b0;
    end else begin
      if (irq_set) irq_r <= 1'b1;
      else if (done && rd_stat) irq_r <= 1'b0;
      if (rst_evt_set) core_rst_evt_r <= 1'b1;
      else if (done && rd_stat) core_rst_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) IRQ_N <= 1'b1;
    else IRQ_N <= !(irq_r && !ctrl_r[`PMIOB_C_PBM]);
  end

  // ------------------------------------------------------------
  // 32 kHz tick and synchronisers
  // ------------------------------------------------------------
  logic [15:0] div_r;
  logic tick_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_r <= 16'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == 16'(TICK_DIV - 1);
      div_r <= (div_r == 16'(TICK_DIV - 1)) ? 16'h0 : div_r + 16'h1;
    end
  end

  // Two flops per input so a slow edge never splits into two events
  logic pb_s1_r, pb_s2_r, pb_prev_r;
  logic p3_s1_r, p3_s2_r, p3_prev_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pb_s1_r <= 1'b1;
      pb_s2_r <= 1'b1;
      p3_s1_r <= 1'b1;
      p3_s2_r <= 1'b1;
    end else begin
      pb_s1_r <= PUSH_BUTTON_I;
      pb_s2_r <= pb_s1_r;
      p3_s1_r <= IO_PIN_THREE_I;
      p3_s2_r <= p3_s1_r;
    end
  end
  assign btn_lvl = pb_s2_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pb_prev_r <= 1'b1;
      p3_prev_r <= 1'b1;
    end else if (tick_r) begin
      pb_prev_r <= pb_s2_r;
      p3_prev_r <= p3_s2_r;
    end
  end
  wire pb_change = tick_r && (pb_s2_r != pb_prev_r);
  wire pb_fall = tick_r && pb_prev_r && !pb_s2_r;
  wire p3_fall = tick_r && p3_prev_r && !p3_s2_r && dc12;

  // ------------------------------------------------------------
  // Push-button state machine
  // ------------------------------------------------------------
  logic [19:0] hold_r;
  logic [19:0] down_r;
  wire [19:0] long_t = ctrl_r[`PMIOB_C_LONG] ? 20'(LONG15_T) :
    20'(LONG8_T);

  // Hold counter restarts on release and after each restart
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) hold_r <= 20'h0;
    else if (tick_r) begin
      if (pb_s2_r || state_r == PMIOB_DOWN) hold_r <= 20'h0;
      else hold_r <= hold_r + 20'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= PMIOB_OFF;
      down_r <= 20'h0;
    end else if (tick_r) begin
      case (state_r)
        PMIOB_OFF: begin
          if (!pb_s2_r && hold_r >= 20'(PWRUP_T - 1))
            state_r <= PMIOB_ACTIVE;
        end
        PMIOB_ACTIVE: begin
          if (!pb_s2_r && hold_r >= long_t - 20'h1) begin
            state_r <= PMIOB_DOWN;
            down_r <= 20'h0;
          end
        end
        PMIOB_DOWN: begin
          down_r <= down_r + 20'h1;
          if (down_r >= 20'(PDOWN_T - 1))
            state_r <= PMIOB_ACTIVE;
        end
        default: state_r <= PMIOB_OFF;
      endcase
    end
  end

  wire active = state_r == PMIOB_ACTIVE;
  assign irq_set = active && pb_change;
  assign rst_evt_set = p3_fall;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) RAILS_EN <= 1'b0;
    else RAILS_EN <= active;
  end

  // Wake pulse: five slow ticks low on each falling button edge while active
  logic [2:0] wake_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) wake_r <= 3'h0;
    else if (tick_r) begin
      if (active && pb_fall) wake_r <= 3'(`PMIOB_WAKE_TICKS);
      else if (wake_r != 3'h0) wake_r <= wake_r - 3'h1;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) WAKE_PULSE_N <= 1'b1;
    else if (tick_r) WAKE_PULSE_N <= !(active && pb_fall) &&
      (wake_r <= 3'h1);
  end

  // ------------------------------------------------------------
  // Rail codes
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAIL3_CODE <= 6'h0;
      RAIL4_CODE <= 6'h0;
    end else if (state_r == PMIOB_OFF || state_r == PMIOB_DOWN) begin
      RAIL3_CODE <= r3_code(SEL_BAND);
      RAIL4_CODE <= r4_code(SEL_BAND);
    end
  end

  // Software writes new targets; pin three falls restore defaults
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r1_target_r <= R1_DEF;
      r2_target_r <= R2_DEF;
    end else if (p3_fall || state_r == PMIOB_DOWN) begin
      r1_target_r <= R1_DEF;
      r2_target_r <= R2_DEF;
    end else if (done && PWRITE && PADDR == `PMIOB_RAIL_OFF) begin
      r1_target_r <= PWDATA[5:0];
      r2_target_r <= PWDATA[11:6];
    end
  end

  // One code step per 2^ramp slow ticks, rails never switched off
  logic [3:0] ramp_cnt_r;
  wire [3:0] ramp_lim = 4'(4'h1 << ctrl_r[`PMIOB_C_RAMP +: 2]);
  wire step = tick_r && ramp_cnt_r >= ramp_lim - 4'h1;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ramp_cnt_r <= 4'h0;
    else if (tick_r) ramp_cnt_r <= step ? 4'h0 : ramp_cnt_r + 4'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAIL1_CODE <= R1_DEF;
      RAIL2_CODE <= R2_DEF;
    end else if (step) begin
      if (RAIL1_CODE < r1_target_r) RAIL1_CODE <= RAIL1_CODE + 6'h1;
      else if (RAIL1_CODE > r1_target_r) RAIL1_CODE <= RAIL1_CODE - 6'h1;
      if (RAIL2_CODE < r2_target_r) RAIL2_CODE <= RAIL2_CODE + 6'h1;
      else if (RAIL2_CODE > r2_target_r) RAIL2_CODE <= RAIL2_CODE - 6'h1;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ramping_r <= 1'b0;
    else ramping_r <= RAIL1_CODE != r1_target_r ||
      RAIL2_CODE != r2_target_r;
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  logic pg_d_r, held_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pg_d_r <= 1'b0;
      held_r <= 1'b0;
    end else begin
      pg_d_r <= POWER_GOOD;
      if (pg_d_r && !POWER_GOOD) held_r <= IO_PIN_ONE_I;
    end
  end

  wire pin1_bit = ctrl_r[`PMIOB_C_SEQ1] ? SEQ_PIN1 : ctrl_r[`PMIOB_C_PIN1_OUTPUT_BIT];
  wire pin3_bit = ctrl_r[`PMIOB_C_SEQ3] ? SEQ_PIN3 : ctrl_r[`PMIOB_C_PIN3_OUTPUT_BIT];
  wire pin2_lvl = !io1sel ? ctrl_r[`PMIOB_C_PIN2_OUTPUT_BIT] :
    (POWER_GOOD ? IO_PIN_ONE_I : held_r);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IO_PIN_ONE_O <= 1'b0;
      IO_PIN_ONE_OE <= 1'b0;
      OUT_PIN_TWO_O <= 1'b0;
      OUT_PIN_TWO_OE <= 1'b1;
      IO_PIN_THREE_O <= 1'b0;
      IO_PIN_THREE_OE <= 1'b0;
    end else begin
      IO_PIN_ONE_O <= 1'b0;
      IO_PIN_ONE_OE <= !io1sel && !pin1_bit;
      OUT_PIN_TWO_O <= pin2_lvl;
      OUT_PIN_TWO_OE <= ctrl_r[`PMIOB_C_BUF2] || !pin2_lvl;
      IO_PIN_THREE_O <= 1'b0;
      IO_PIN_THREE_OE <= !dc12 && !pin3_bit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pin3_quiet;
    @(posedge CLK) disable iff (RST) $past(dc12) |-> !IO_PIN_THREE_OE;
  endproperty
  a_pin3_quiet: assert property (p_pin3_quiet)
    else $error("pin three driven in reset mode");
  property p_pin1_quiet;
    @(posedge CLK) disable iff (RST) $past(io1sel) |-> !IO_PIN_ONE_OE;
  endproperty
  a_pin1_quiet: assert property (p_pin1_quiet)
    else $error("pin one driven in input mode");
  // Read data is loaded at setup, so it stands in the access cycle
  property p_flag;
    @(posedge CLK) disable iff (RST) rd_stat && PREADY |->
      PRDATA[`PMIOB_S_LEVEL] == $past(btn_lvl);
  endproperty
  a_flag: assert property (p_flag)
    else $error("level flag wrong");
  property p_irq;
    @(posedge CLK) disable iff (RST) irq_set |=> irq_r;
  endproperty
  a_irq: assert property (p_irq)
    else $error("button event lost");
  property p_wake;
    @(posedge CLK) disable iff (RST)
      tick_r && active && pb_fall |=> !WAKE_PULSE_N;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse missing");
  property p_restore;
    @(posedge CLK) disable iff (RST)
      p3_fall |=> r1_target_r == R1_DEF && r2_target_r == R2_DEF;
  endproperty
  a_restore: assert property (p_restore)
    else $error("rail targets not restored");
  property p_pin2_od;
    @(posedge CLK) disable iff (RST)
      !ctrl_r[`PMIOB_C_BUF2] && $stable(ctrl_r) ##1 OUT_PIN_TWO_OE
        |-> !OUT_PIN_TWO_O;
  endproperty
  a_pin2_od: assert property (p_pin2_od)
    else $error("open-drain pin two driven high");
  property p_down;
    @(posedge CLK) disable iff (RST) state_r == PMIOB_DOWN |=> !RAILS_EN;
  endproperty
  a_down: assert property (p_down)
    else $error("rails on during power-down");

endmodule
